// ==== inc/sdram_bank_map.svh ====
`ifndef SDRAM_BANK_MAP_SVH
`define SDRAM_BANK_MAP_SVH

// ------------------------------------------------------------
// pin vector layout {cke, cs_n, ras_n, cas_n, we_n, addr[11:0]}
// ------------------------------------------------------------
`define PIN_W        17
`define PIN_IDLE     17'h1_F000
`define PIN_CKE      16
`define PIN_CS_N     15
`define PIN_RAS_N    14
`define PIN_CAS_N    13
`define PIN_WE_N     12
`define PIN_BANK     11
`define PIN_AP       10
`define COL_W        8

// ------------------------------------------------------------
// mode opcode fields and reset value (burst 1, latency 2)
// ------------------------------------------------------------
`define MODE_W       12
`define MODE_RESET   12'h020
`define MODE_BL_MSB  2
`define MODE_BL_LSB  0
`define MODE_CL_MSB  6
`define MODE_CL_LSB  4
`define MODE_CL3     3'h3
`define BL_FULL      3'h7

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_PS       5000
`define WR_REC_PS    10000
`define PRE_PS       20000
`define WR_REC_CYC   ((`WR_REC_PS + `CLK_PS - 1) / `CLK_PS)
`define PRE_CYC      ((`PRE_PS + `CLK_PS - 1) / `CLK_PS)

`endif

// ==== inc/sdram_bank_pkg.sv ====
package sdram_bank_pkg;

    typedef enum logic [3:0] {
        st_idle,
        st_active,
        st_read,
        st_read_ap,
        st_write,
        st_wr_rec,
        st_precharge,
        st_power_down,
        st_self_refresh
    } bank_state_t;

    typedef enum logic [3:0] {
        c_deselect,
        c_nop,
        c_burst_stop,
        c_read,
        c_read_ap,
        c_write,
        c_write_ap,
        c_row_open,
        c_close,
        c_refresh,
        c_mode_load
    } cmd_t;

endpackage

// ==== core/sdram_bank_fsm.sv ====
// Contract
// [RULE1] idle: deselect, nop, burst stop do nothing, or power-down when clock enable low
// [RULE2] idle: open moves to active; close ignored; refresh, mode load act; read/write illegal
// [RULE3] active: read/write start burst, close precharges; open, refresh, mode load illegal
// [RULE4] read burst: nop lets burst finish, then bank returns to active
// [RULE5] read burst: burst stop ends it, bank active
// [RULE6] read burst: new read restarts burst at new column
// [RULE7] read burst: write ends read and starts write burst
// [RULE8] read burst: close ends read and precharges addressed or both banks
// [RULE9] write burst: nop lets burst finish, then write recovery
// [RULE10] write burst: burst stop ends it, bank active
// [RULE11] write burst: read ends write and starts read at new column
// [RULE12] write burst: new write restarts at new column
// [RULE13] write burst: close ends write and precharges addressed or both banks
// [RULE14] read with auto close: nop lets burst finish, then precharge
// [RULE15] read with auto close: controller sends only deselect or nop
// [RULE16] after burst stop, data keeps driving for the read latency
// [RULE17] power-down on clock enable falling while idle, held while low
// [RULE18] write recovery ends in active after the recovery interval; the code goes to precharge instead when the write had auto close
`timescale 1ns/1ps
`default_nettype none
`include "sdram_bank_map.svh"

module sdram_bank_fsm #(
    parameter logic bank_id = 1'b0
) (
    input  wire logic                        clk,
    input  wire logic                        nrst,
    input  wire logic                        cke_pin,
    input  wire logic                        cs_n_pin,
    input  wire logic                        ras_n_pin,
    input  wire logic                        cas_n_pin,
    input  wire logic                        we_n_pin,
    input  wire logic [11:0]                 addr_pin,
    output var  sdram_bank_pkg::bank_state_t state_q,
    output logic [`COL_W-1:0]                col_q,
    output logic                             dq_drive_q,
    output logic                             wr_accept_q,
    output logic [`MODE_W-1:0]               mode_q,
    output logic                             refresh_q,
    output logic                             illegal_q
);

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    logic [`PIN_W-1:0] s1_q;
    logic [`PIN_W-1:0] s2_q;
    logic              cke_prev_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_q       <= `PIN_IDLE;
            s2_q       <= `PIN_IDLE;
            cke_prev_q <= 1'b1;
        end else begin
            s1_q       <= {cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin, addr_pin};
            s2_q       <= s1_q;
            cke_prev_q <= s2_q[`PIN_CKE];
        end
    end

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    sdram_bank_pkg::cmd_t cmd;
    logic                 cke;
    logic                 cmd_ok;
    logic                 hit;
    logic                 close_hit;
    logic [`COL_W-1:0]    new_col;

    assign cke       = s2_q[`PIN_CKE];
    assign cmd_ok    = cke_prev_q;
    assign hit       = s2_q[`PIN_BANK] == bank_id;
    assign close_hit = hit || s2_q[`PIN_AP];
    assign new_col   = s2_q[`COL_W-1:0];

    // commands aimed at the other bank look like a nop here
    always_comb begin
        cmd = sdram_bank_pkg::c_nop;
        if (s2_q[`PIN_CS_N]) begin
            cmd = sdram_bank_pkg::c_deselect;
        end else begin
            case (s2_q[`PIN_RAS_N:`PIN_WE_N])
                3'h0: cmd = sdram_bank_pkg::c_mode_load;
                3'h1: cmd = sdram_bank_pkg::c_refresh;
                3'h2: if (close_hit) begin
                    cmd = sdram_bank_pkg::c_close;
                end
                3'h3: if (hit) begin
                    cmd = sdram_bank_pkg::c_row_open;
                end
                3'h4: if (hit) begin
                    cmd = s2_q[`PIN_AP] ? sdram_bank_pkg::c_write_ap
                                        : sdram_bank_pkg::c_write;
                end
                3'h5: if (hit) begin
                    cmd = s2_q[`PIN_AP] ? sdram_bank_pkg::c_read_ap
                                        : sdram_bank_pkg::c_read;
                end
                3'h6: cmd = sdram_bank_pkg::c_burst_stop;
                default: cmd = sdram_bank_pkg::c_nop;
            endcase
        end
    end

    // ------------------------------------------------------------
    // burst length and latency from the mode opcode
    // ------------------------------------------------------------
    logic [`COL_W-1:0] burst_last;
    logic              cl3;

    assign cl3 = mode_q[`MODE_CL_MSB:`MODE_CL_LSB] == `MODE_CL3;

    always_comb begin
        case (mode_q[`MODE_BL_MSB:`MODE_BL_LSB])
            3'h0:     burst_last = 8'h00;
            3'h1:     burst_last = 8'h01;
            3'h2:     burst_last = 8'h03;
            3'h3:     burst_last = 8'h07;
            `BL_FULL: burst_last = 8'hFF;
            default:  burst_last = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // bank state machine
    // ------------------------------------------------------------
    sdram_bank_pkg::bank_state_t state_d;
    logic [`COL_W-1:0]           col_d;
    logic [`COL_W-1:0]           cnt_q;
    logic [`COL_W-1:0]           cnt_d;
    logic                        ap_q;
    logic                        ap_d;
    logic [`MODE_W-1:0]          mode_d;
    logic                        refresh_d;
    logic                        illegal_d;
    logic                        last;
    logic                        quiet;
    logic                        is_rd;
    logic                        is_wr;

    assign last  = cnt_q == 8'h00;
    assign quiet = cmd == sdram_bank_pkg::c_deselect || cmd == sdram_bank_pkg::c_nop;
    assign is_rd = cmd == sdram_bank_pkg::c_read || cmd == sdram_bank_pkg::c_read_ap;
    assign is_wr = cmd == sdram_bank_pkg::c_write || cmd == sdram_bank_pkg::c_write_ap;

    always_comb begin
        state_d   = state_q;
        col_d     = col_q;
        cnt_d     = cnt_q;
        ap_d      = ap_q;
        mode_d    = mode_q;
        refresh_d = 1'b0;
        illegal_d = 1'b0;
        if (state_q == sdram_bank_pkg::st_power_down
                || state_q == sdram_bank_pkg::st_self_refresh) begin
            if (cke) begin
                state_d = sdram_bank_pkg::st_idle; // RULE17
            end
        end else if (cmd_ok) begin
            // low clock enable on the previous edge freezes state, column, count and mode, not the read data pipeline
            case (state_q)
                sdram_bank_pkg::st_idle: begin
                    if (quiet || cmd == sdram_bank_pkg::c_burst_stop) begin
                        if (!cke) begin
                            state_d = sdram_bank_pkg::st_power_down; // RULE1 RULE17
                        end
                    end else if (cmd == sdram_bank_pkg::c_row_open) begin
                        state_d = sdram_bank_pkg::st_active; // RULE2
                    end else if (cmd == sdram_bank_pkg::c_refresh) begin
                        if (!cke) begin
                            state_d = sdram_bank_pkg::st_self_refresh; // RULE2
                        end else begin
                            refresh_d = 1'b1; // RULE2
                        end
                    end else if (cmd == sdram_bank_pkg::c_mode_load) begin
                        mode_d = s2_q[`MODE_W-1:0]; // RULE2
                    end else if (is_rd || is_wr) begin
                        illegal_d = 1'b1; // RULE2
                    end
                end
                sdram_bank_pkg::st_active,
                sdram_bank_pkg::st_read,
                sdram_bank_pkg::st_write,
                sdram_bank_pkg::st_wr_rec: begin
                    if (is_rd) begin
                        state_d = (cmd == sdram_bank_pkg::c_read_ap)
                                ? sdram_bank_pkg::st_read_ap
                                : sdram_bank_pkg::st_read; // RULE3 RULE6 RULE11
                        col_d   = new_col;
                        cnt_d   = burst_last;
                    end else if (is_wr) begin
                        state_d = sdram_bank_pkg::st_write; // RULE3 RULE7 RULE12
                        col_d   = new_col;
                        cnt_d   = burst_last;
                        ap_d    = cmd == sdram_bank_pkg::c_write_ap;
                    end else if (cmd == sdram_bank_pkg::c_close
                            && state_q != sdram_bank_pkg::st_wr_rec) begin
                        state_d = sdram_bank_pkg::st_precharge; // RULE3 RULE8 RULE13
                        cnt_d   = 8'(`PRE_CYC - 1);
                    end else if (cmd == sdram_bank_pkg::c_burst_stop
                            && state_q != sdram_bank_pkg::st_wr_rec) begin
                        state_d = sdram_bank_pkg::st_active; // RULE5 RULE10
                    end else if (quiet || cmd == sdram_bank_pkg::c_burst_stop) begin
                        case (state_q)
                            sdram_bank_pkg::st_read: begin
                                if (last) begin
                                    state_d = sdram_bank_pkg::st_active; // RULE4
                                end else begin
                                    cnt_d = cnt_q - 8'h01;
                                    col_d = col_q + 8'h01;
                                end
                            end
                            sdram_bank_pkg::st_write: begin
                                if (last) begin
                                    state_d = sdram_bank_pkg::st_wr_rec; // RULE9
                                    cnt_d   = 8'(`WR_REC_CYC - 1);
                                end else begin
                                    cnt_d = cnt_q - 8'h01;
                                    col_d = col_q + 8'h01;
                                end
                            end
                            sdram_bank_pkg::st_wr_rec: begin
                                if (!last) begin
                                    cnt_d = cnt_q - 8'h01;
                                end else if (ap_q) begin
                                    state_d = sdram_bank_pkg::st_precharge;
                                    cnt_d   = 8'(`PRE_CYC - 1);
                                end else begin
                                    state_d = sdram_bank_pkg::st_active; // RULE18
                                end
                            end
                            default: ;
                        endcase
                    end else begin
                        illegal_d = 1'b1; // RULE3
                    end
                end
                sdram_bank_pkg::st_read_ap: begin
                    if (quiet) begin
                        if (last) begin
                            state_d = sdram_bank_pkg::st_precharge; // RULE14
                            cnt_d   = 8'(`PRE_CYC - 1);
                        end else begin
                            cnt_d = cnt_q - 8'h01;
                            col_d = col_q + 8'h01;
                        end
                    end else begin
                        illegal_d = 1'b1; // RULE15
                    end
                end
                sdram_bank_pkg::st_precharge: begin
                    if (last) begin
                        state_d = sdram_bank_pkg::st_idle;
                    end else begin
                        cnt_d = cnt_q - 8'h01;
                    end
                    if (is_rd || is_wr || cmd == sdram_bank_pkg::c_row_open) begin
                        illegal_d = 1'b1;
                    end
                end
                default: state_d = sdram_bank_pkg::st_idle;
            endcase
        end
    end

    // ------------------------------------------------------------
    // read data pipeline: drive lags the burst by the latency,
    // so a stopped burst still drives for that many cycles
    // ------------------------------------------------------------
    logic [1:0] pipe_q;
    logic [1:0] pipe_d;
    logic       rd_beat;
    logic       dq_drive_d;
    logic       wr_accept_d;

    assign rd_beat = state_q == sdram_bank_pkg::st_read
                  || state_q == sdram_bank_pkg::st_read_ap;

    always_comb begin
        pipe_d      = {pipe_q[0], rd_beat};
        dq_drive_d  = cl3 ? pipe_q[1] : pipe_q[0]; // RULE16
        wr_accept_d = state_d == sdram_bank_pkg::st_write;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q     <= sdram_bank_pkg::st_idle;
            col_q       <= 8'h00;
            cnt_q       <= 8'h00;
            ap_q        <= 1'b0;
            mode_q      <= `MODE_RESET;
            refresh_q   <= 1'b0;
            illegal_q   <= 1'b0;
            pipe_q      <= 2'h0;
            dq_drive_q  <= 1'b0;
            wr_accept_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            col_q       <= col_d;
            cnt_q       <= cnt_d;
            ap_q        <= ap_d;
            mode_q      <= mode_d;
            refresh_q   <= refresh_d;
            illegal_q   <= illegal_d;
            pipe_q      <= pipe_d;
            dq_drive_q  <= dq_drive_d;
            wr_accept_q <= wr_accept_d;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence in_s(sdram_bank_pkg::bank_state_t s);
        state_q == s && cmd_ok;
    endsequence

    sequence rd_stop_s;
        in_s(sdram_bank_pkg::st_read) ##0 cmd == sdram_bank_pkg::c_burst_stop;
    endsequence

    idle_quiet_a: assert property (in_s(sdram_bank_pkg::st_idle) ##0 quiet ##0 cke
        |=> state_q == sdram_bank_pkg::st_idle)
        else $error("idle quiet left idle"); // RULE1
    idle_open_a: assert property (in_s(sdram_bank_pkg::st_idle)
        ##0 cmd == sdram_bank_pkg::c_row_open |=> state_q == sdram_bank_pkg::st_active)
        else $error("open did not activate"); // RULE2
    active_rw_a: assert property (in_s(sdram_bank_pkg::st_active) ##0 (is_rd || is_wr)
        |=> (rd_beat || wr_accept_q) && col_q == $past(new_col))
        else $error("burst not started"); // RULE3
    rd_end_a: assert property (in_s(sdram_bank_pkg::st_read) ##0 quiet ##0 last
        |=> state_q == sdram_bank_pkg::st_active)
        else $error("read end not active"); // RULE4
    rd_stop_a: assert property (rd_stop_s |=> state_q == sdram_bank_pkg::st_active)
        else $error("read stop failed"); // RULE5
    rd_restart_a: assert property (in_s(sdram_bank_pkg::st_read) ##0 is_rd
        |=> rd_beat && col_q == $past(new_col) && cnt_q == burst_last)
        else $error("read restart failed"); // RULE6
    rd_to_wr_a: assert property (in_s(sdram_bank_pkg::st_read) ##0 is_wr
        |=> state_q == sdram_bank_pkg::st_write && wr_accept_q && !rd_beat)
        else $error("read to write failed"); // RULE7
    rd_close_a: assert property (in_s(sdram_bank_pkg::st_read)
        ##0 cmd == sdram_bank_pkg::c_close |=> state_q == sdram_bank_pkg::st_precharge)
        else $error("read close failed"); // RULE8
    wr_end_a: assert property (in_s(sdram_bank_pkg::st_write) ##0 quiet ##0 last
        |=> state_q == sdram_bank_pkg::st_wr_rec)
        else $error("write end not recovery"); // RULE9
    wr_stop_a: assert property (in_s(sdram_bank_pkg::st_write)
        ##0 cmd == sdram_bank_pkg::c_burst_stop |=> state_q == sdram_bank_pkg::st_active)
        else $error("write stop failed"); // RULE10
    wr_to_rd_a: assert property (in_s(sdram_bank_pkg::st_write) ##0 is_rd
        |=> rd_beat && col_q == $past(new_col))
        else $error("write to read failed"); // RULE11
    wr_restart_a: assert property (in_s(sdram_bank_pkg::st_write) ##0 is_wr
        |=> wr_accept_q && col_q == $past(new_col))
        else $error("write restart failed"); // RULE12
    wr_close_a: assert property (in_s(sdram_bank_pkg::st_write)
        ##0 cmd == sdram_bank_pkg::c_close |=> state_q == sdram_bank_pkg::st_precharge)
        else $error("write close failed"); // RULE13
    rap_end_a: assert property (in_s(sdram_bank_pkg::st_read_ap) ##0 quiet ##0 last
        |=> state_q == sdram_bank_pkg::st_precharge)
        else $error("auto close missing"); // RULE14
    stop_drive_a: assert property (rd_stop_s ##0 !cl3 ##0 rd_beat
        |-> ##2 dq_drive_q)
        else $error("drive cut before latency"); // RULE16
    pd_hold_a: assert property (state_q == sdram_bank_pkg::st_power_down ##0 !cke
        |=> state_q == sdram_bank_pkg::st_power_down)
        else $error("power-down left early"); // RULE17
    rec_end_a: assert property (in_s(sdram_bank_pkg::st_wr_rec) ##0 quiet ##0 last ##0 !ap_q
        |=> state_q == sdram_bank_pkg::st_active)
        else $error("recovery end not active"); // RULE18

endmodule

`default_nettype wire

// ==== verif/ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// controller side: command code to pins
// ----------------------------------------
module ctrl_model (
    input  var  sdram_bank_pkg::cmd_t cmd,
    input  wire logic [11:0]          addr_in,
    input  wire logic                 cke_in,
    output logic                      cke_pin,
    output logic                      cs_n_pin,
    output logic                      ras_n_pin,
    output logic                      cas_n_pin,
    output logic                      we_n_pin,
    output logic [11:0]               addr_pin
);
    logic [3:0] pins;

    always_comb begin
        addr_pin = addr_in;
        case (cmd)
            sdram_bank_pkg::c_deselect: pins = 4'hF;
            sdram_bank_pkg::c_burst_stop: pins = 4'h6;
            sdram_bank_pkg::c_read, sdram_bank_pkg::c_read_ap: pins = 4'h5;
            sdram_bank_pkg::c_write, sdram_bank_pkg::c_write_ap: pins = 4'h4;
            sdram_bank_pkg::c_row_open: pins = 4'h3;
            sdram_bank_pkg::c_close: pins = 4'h2;
            sdram_bank_pkg::c_refresh: pins = 4'h1;
            sdram_bank_pkg::c_mode_load: pins = 4'h0;
            default: pins = 4'h7;
        endcase
        // auto close travels on address bit 10
        if (cmd == sdram_bank_pkg::c_read_ap || cmd == sdram_bank_pkg::c_write_ap) begin
            addr_pin[10] = 1'b1;
        end else if (cmd == sdram_bank_pkg::c_read || cmd == sdram_bank_pkg::c_write) begin
            addr_pin[10] = 1'b0;
        end
        {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} = pins;
        cke_pin = cke_in;
    end
endmodule
`default_nettype wire

// ==== verif/tb_sdram_bank_command_state_machine.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sdram_bank_map.svh"

module tb_sdram_bank_command_state_machine;
    logic                        clk = 1'b0;
    logic                        nrst = 1'b0;
    logic                        cke = 1'b1;
    sdram_bank_pkg::cmd_t        cmd = sdram_bank_pkg::c_nop;
    logic [11:0]                 addr = 12'h000;
    logic                        cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin;
    logic [11:0]                 addr_pin;
    sdram_bank_pkg::bank_state_t state_q;
    logic [`COL_W-1:0]           col_q;
    logic                        dq_drive_q, wr_accept_q, refresh_q, illegal_q;
    logic [`MODE_W-1:0]          mode_q;
    int                          miscompares = 0;
    int                          compares = 0;

    always #2.5 clk = ~clk;

    ctrl_model ctrl (.cmd(cmd), .addr_in(addr), .cke_in(cke), .cke_pin(cke_pin),
        .cs_n_pin(cs_n_pin), .ras_n_pin(ras_n_pin), .cas_n_pin(cas_n_pin),
        .we_n_pin(we_n_pin), .addr_pin(addr_pin));

    sdram_bank_fsm #(.bank_id(1'b0)) DUT (.clk(clk), .nrst(nrst), .cke_pin(cke_pin),
        .cs_n_pin(cs_n_pin), .ras_n_pin(ras_n_pin), .cas_n_pin(cas_n_pin),
        .we_n_pin(we_n_pin), .addr_pin(addr_pin), .state_q(state_q), .col_q(col_q),
        .dq_drive_q(dq_drive_q), .wr_accept_q(wr_accept_q), .mode_q(mode_q),
        .refresh_q(refresh_q), .illegal_q(illegal_q));

    // ----------------------------------------
    // compare and drive helpers
    // ----------------------------------------
    task automatic chk_state(input sdram_bank_pkg::bank_state_t exp);
        compares++;
        if (state_q !== exp) begin
            miscompares++;
            $display("BAD %0t state %0d want %0d", $time, state_q, exp);
        end
    endtask

    task automatic chk_bits(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t value %h want %h", $time, got, exp);
        end
    endtask

    // effect of a command shows three falling edges after it is driven
    task automatic issue(input sdram_bank_pkg::cmd_t c, input logic [11:0] a);
        cmd = c;
        addr = a;
        @(negedge clk);
        cmd = sdram_bank_pkg::c_nop;
        repeat (2) @(negedge clk);
    endtask

    task automatic wait_state(input sdram_bank_pkg::bank_state_t exp, input int lim);
        for (int i = 0; i < lim && state_q !== exp; i++) @(negedge clk);
        chk_state(exp);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_idle;
        issue(sdram_bank_pkg::c_burst_stop, 12'h000);
        chk_state(sdram_bank_pkg::st_idle);
        cke = 1'b0;
        issue(sdram_bank_pkg::c_nop, 12'h000);
        repeat (3) @(negedge clk);
        chk_state(sdram_bank_pkg::st_power_down);
        cke = 1'b1;
        wait_state(sdram_bank_pkg::st_idle, 6);
        issue(sdram_bank_pkg::c_read, 12'h005);
        chk_bits({11'h000, illegal_q}, 12'h001);
        issue(sdram_bank_pkg::c_close, 12'h000);
        chk_state(sdram_bank_pkg::st_idle);
        issue(sdram_bank_pkg::c_mode_load, 12'h023);
        chk_bits(mode_q, 12'h023);
        issue(sdram_bank_pkg::c_refresh, 12'h000);
        chk_bits({11'h000, refresh_q}, 12'h001);
    endtask

    task automatic t_read;
        issue(sdram_bank_pkg::c_row_open, 12'h000);
        chk_state(sdram_bank_pkg::st_active);
        issue(sdram_bank_pkg::c_row_open, 12'h000);
        chk_bits({11'h000, illegal_q}, 12'h001);
        issue(sdram_bank_pkg::c_read, 12'h005);
        chk_bits({state_q == sdram_bank_pkg::st_read, 3'h0, col_q}, 12'h805);
        issue(sdram_bank_pkg::c_read, 12'h009);
        chk_bits({4'h0, col_q}, 12'h009);
        issue(sdram_bank_pkg::c_burst_stop, 12'h000);
        chk_state(sdram_bank_pkg::st_active);
        chk_bits({11'h000, dq_drive_q}, 12'h001);
        repeat (4) @(negedge clk);
        chk_bits({11'h000, dq_drive_q}, 12'h000);
        issue(sdram_bank_pkg::c_read, 12'h000);
        wait_state(sdram_bank_pkg::st_active, 12);
    endtask

    task automatic t_write;
        issue(sdram_bank_pkg::c_read, 12'h001);
        issue(sdram_bank_pkg::c_write, 12'h002);
        chk_bits({state_q == sdram_bank_pkg::st_write, 10'h000, wr_accept_q}, 12'h801);
        issue(sdram_bank_pkg::c_write, 12'h01E);
        chk_bits({4'h0, col_q}, 12'h01E);
        issue(sdram_bank_pkg::c_read, 12'h028);
        chk_bits({state_q == sdram_bank_pkg::st_read, 3'h0, col_q}, 12'h828);
        issue(sdram_bank_pkg::c_write, 12'h003);
        issue(sdram_bank_pkg::c_burst_stop, 12'h000);
        chk_bits({state_q == sdram_bank_pkg::st_active, 10'h000, wr_accept_q}, 12'h800);
        issue(sdram_bank_pkg::c_write, 12'h006);
        wait_state(sdram_bank_pkg::st_wr_rec, 12);
        wait_state(sdram_bank_pkg::st_active, 4);
    endtask

    task automatic t_close;
        issue(sdram_bank_pkg::c_read, 12'h004);
        issue(sdram_bank_pkg::c_close, 12'h000);
        chk_state(sdram_bank_pkg::st_precharge);
        wait_state(sdram_bank_pkg::st_idle, 8);
        issue(sdram_bank_pkg::c_row_open, 12'h000);
        issue(sdram_bank_pkg::c_write, 12'h005);
        issue(sdram_bank_pkg::c_close, 12'hC00);
        chk_state(sdram_bank_pkg::st_precharge);
        wait_state(sdram_bank_pkg::st_idle, 8);
        issue(sdram_bank_pkg::c_row_open, 12'h000);
        // only no-operation follows while the auto close read runs
        issue(sdram_bank_pkg::c_read_ap, 12'h007);
        chk_state(sdram_bank_pkg::st_read_ap);
        wait_state(sdram_bank_pkg::st_precharge, 12);
        wait_state(sdram_bank_pkg::st_idle, 8);
    endtask

    // latency 3, burst 4: drive must outlast a stop by one more cycle
    task automatic t_latency;
        issue(sdram_bank_pkg::c_mode_load, 12'h032);
        issue(sdram_bank_pkg::c_row_open, 12'h000);
        issue(sdram_bank_pkg::c_read, 12'h010);
        issue(sdram_bank_pkg::c_burst_stop, 12'h000);
        repeat (2) @(negedge clk);
        chk_bits({11'h000, dq_drive_q}, 12'h001);
        @(negedge clk);
        chk_bits({11'h000, dq_drive_q}, 12'h000);
    endtask

    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic stop_test;
        if (miscompares == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #5000;
        miscompares++;
        stop_test();
    end

    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        t_idle();
        t_read();
        t_write();
        t_close();
        t_latency();
        stop_test();
    end
endmodule
`default_nettype wire
